/* File: src/ios_status_maint.sv */
`timescale 1ns/1ps
module ios_status_maint
   import ios_pkg::*;
#(
   parameter logic [39:0] HOUR_CYCLES = HOUR_CYC,
   parameter logic [15:0] FW_VERSION  = 16'h0100   // arbitrary value
) (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire ios_terms_t  TERMS,
   input  wire logic        FAN_ONOFF_CONTROL,
   input  wire logic        FAN_RUNNING,
   input  wire logic        RUN_CMD,
   input  wire logic        LINK_ERR,
   input  wire logic [15:0] LINK_ERR_CODE,
   input  wire logic [7:0]  HEATSINK_TEMP,
   input  wire logic [15:0] OUT_CURRENT,
   input  wire logic [15:0] CAP_MEAS,
   input  wire logic [15:0] CAP_SHIP,
   input  wire logic        KEYPAD_ATTACHED,
   input  wire logic [15:0] KEYPAD_FW_VER,
   input  wire logic [1:0]  KEYPAD_MENU_SCOPE,
   input  wire ios_item_t   ITEM_SEL,
   output logic      [15:0] IN_STATUS,
   output logic      [15:0] OUT_STATUS,
   output logic      [15:0] LINK_STATUS,
   output ios_digits_t      DISP,
   output logic             DISP_COARSE,
   output logic             ITEM_VALID,
   output logic             MENU_SWITCH_OK
);

   // scale an hour or startup count: unit steps below 10000, tens above
   function automatic logic [15:0] scale(input logic [15:0] v);
      scale = (v < FINE_LIMIT) ? v : v / SCALE_DIV;
   endfunction

   // saturating increment used by the counters that must not wrap
   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      sat_inc = (v == CNT_MAX) ? v : v + 16'h0001;
   endfunction

   ios_state_t  s_q;
   ios_state_t  s_d;
   logic [15:0] in_word;
   logic [15:0] link_word;
   logic [15:0] out_word;
   logic [23:0] cap_prod;
   logic [15:0] cap_pct;
   logic [15:0] shown;
   logic        fan_counts;

   // terminal words; bits with no terminal stay zero
   always_comb begin
      in_word                 = 16'h0000;
      in_word[BIT_FWD]        = TERMS.forward_run_input;
      in_word[BIT_BWD]        = TERMS.backward_run_input;
      in_word[BIT_GEN1]       = TERMS.gen_input_one;
      in_word[BIT_GEN1 + 1]   = TERMS.gen_input_two;
      in_word[BIT_GEN1 + 2]   = TERMS.gen_input_three;
      link_word               = in_word;
      link_word[BIT_LFWD]     = TERMS.link_forward_cmd;
      link_word[BIT_LBWD]     = TERMS.link_backward_cmd;
      out_word                = 16'h0000;
      out_word[BIT_TOUT]      = TERMS.transistor_output;
      out_word[BIT_RELAY]     = TERMS.relay_make_contact;
   end

   // capacitance against shipment value; zero reference reads as 0 rather than dividing
   assign cap_prod = 24'(CAP_MEAS) * PCT_FULL;
   assign cap_pct  = (CAP_SHIP == 16'h0000) ? 16'h0000
                   : 16'(cap_prod / {8'h00, CAP_SHIP});

   // fan time is frozen only when on/off control is active and the fan is off
   assign fan_counts = !(FAN_ONOFF_CONTROL && !FAN_RUNNING);

   always_comb begin
      s_d = s_q;

      // hour timebase; a parameter so simulation can shorten the hour
      s_d.tick = 1'b0;
      if (s_q.pre >= HOUR_CYCLES - 40'h1) begin
         s_d.pre  = 40'h0;
         s_d.tick = 1'b1;
      end else begin
         s_d.pre = s_q.pre + 40'h1;
      end

      // hour counters step one cycle after the timebase pulse
      if (s_q.tick) begin
         s_d.hrs_run = s_q.hrs_run + 16'h0001;                 // wraps past 65535
         s_d.hrs_board = sat_inc(s_q.hrs_board);
         if (fan_counts) begin
            s_d.hrs_fan = sat_inc(s_q.hrs_fan);
         end
      end

      // startups counted on the run command's rising edge
      s_d.run_prev = RUN_CMD;
      if (RUN_CMD && !s_q.run_prev) begin
         s_d.starts = sat_inc(s_q.starts);
      end

      // link errors: wrap after the largest shown value, keep newest code
      if (LINK_ERR) begin
         s_d.err_cnt  = (s_q.err_cnt >= ERR_MAX) ? 16'h0000
                      : s_q.err_cnt + 16'h0001;
         s_d.err_code = LINK_ERR_CODE;
      end

      // running maxima restart at each hour and hand over the finished hour
      if (s_q.tick) begin
         s_d.temp_max = s_q.temp_run;
         s_d.cur_max  = s_q.cur_run;
         s_d.temp_run = HEATSINK_TEMP;
         s_d.cur_run  = OUT_CURRENT;
      end else begin
         if (HEATSINK_TEMP > s_q.temp_run) begin
            s_d.temp_run = HEATSINK_TEMP;
         end
         if (OUT_CURRENT > s_q.cur_run) begin
            s_d.cur_run = OUT_CURRENT;
         end
      end

      s_d.in_word   = in_word;
      s_d.out_word  = out_word;
      s_d.link_word = link_word;
      s_d.menu_ok   = (KEYPAD_MENU_SCOPE == SCOPE_FULL);

      // item selection for the four-digit readout
      shown    = 16'h0000;
      s_d.valid  = 1'b1;
      s_d.coarse = 1'b0;
      case (ITEM_SEL)
         ITM_IO_TERM: begin
            shown = in_word | out_word;
         end
         ITM_IO_LINK: begin
            shown = link_word;
         end
         ITM_RUN_HRS: begin
            shown      = scale(s_q.hrs_run);
            s_d.coarse = (s_q.hrs_run >= FINE_LIMIT);
         end
         ITM_BOARD_HRS: begin
            shown      = scale(s_q.hrs_board);
            s_d.coarse = (s_q.hrs_board >= FINE_LIMIT);
         end
         ITM_FAN_HRS: begin
            shown      = scale(s_q.hrs_fan);
            s_d.coarse = (s_q.hrs_fan >= FINE_LIMIT);
         end
         ITM_STARTS: begin
            shown      = scale(s_q.starts);
            s_d.coarse = (s_q.starts >= FINE_LIMIT);
         end
         ITM_MAX_TEMP: begin
            shown = {8'h00, s_q.temp_max};
         end
         ITM_MAX_CUR: begin
            shown = s_q.cur_max;
         end
         ITM_CAP_PCT: begin
            shown = cap_pct;
         end
         ITM_LINK_ERRS: begin
            shown = s_q.err_cnt;
         end
         ITM_LINK_CODE: begin
            shown = s_q.err_code;
         end
         ITM_FW_VER: begin
            shown = FW_VERSION;
         end
         ITM_KP_VER: begin
            shown     = KEYPAD_ATTACHED ? KEYPAD_FW_VER : 16'h0000;
            s_d.valid = KEYPAD_ATTACHED;
         end
         default: begin
            s_d.valid = 1'b0;
         end
      endcase
      s_d.digits = ios_digits_t'(shown);
   end

   // synchronous reset; clears counters and maxima, as do the hrs_run and err_cnt wraps; the hourly restart loads the running maxima with the present inputs
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign IN_STATUS      = s_q.in_word;
   assign OUT_STATUS     = s_q.out_word;
   assign LINK_STATUS    = s_q.link_word;
   assign DISP           = s_q.digits;
   assign DISP_COARSE    = s_q.coarse;
   assign ITEM_VALID     = s_q.valid;
   assign MENU_SWITCH_OK = s_q.menu_ok;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   a_in_mapping: assert property (
      ##1 IN_STATUS[4:0] == {$past(TERMS.gen_input_three), $past(TERMS.gen_input_two),
                             $past(TERMS.gen_input_one), $past(TERMS.backward_run_input),
                             $past(TERMS.forward_run_input)})
      else $error("input status bits do not follow the terminals");

   a_unused_zero: assert property (
      IN_STATUS[15:5] == 11'h000 && OUT_STATUS[15:9] == 7'h00 && OUT_STATUS[7:1] == 7'h00)
      else $error("unassigned status bit is set");

   a_relay_bit: assert property (
      ##1 OUT_STATUS[8] == $past(TERMS.relay_make_contact)
          && OUT_STATUS[0] == $past(TERMS.transistor_output))
      else $error("output status bits do not follow the contacts");

   a_run_wrap: assert property (
      s_q.tick && s_q.hrs_run == CNT_MAX |=> s_q.hrs_run == 16'h0000)
      else $error("power-on hours did not wrap to zero");

   a_board_hold: assert property (
      s_q.hrs_board == CNT_MAX |=> s_q.hrs_board == CNT_MAX)
      else $error("board capacitor hours left their maximum");

   a_fan_frozen: assert property (
      s_q.tick && FAN_ONOFF_CONTROL && !FAN_RUNNING |=> $stable(s_q.hrs_fan))
      else $error("fan hours advanced while the fan was stopped");

   a_start_count: assert property (
      RUN_CMD && !s_q.run_prev && s_q.starts != CNT_MAX
      |=> s_q.starts == $past(s_q.starts) + 16'h0001)
      else $error("startup was not counted");

   a_err_wrap: assert property (
      LINK_ERR && s_q.err_cnt == ERR_MAX |=> s_q.err_cnt == 16'h0000 ##1 s_q.err_cnt <= ERR_MAX)
      else $error("link error count did not return to zero");

   a_err_code: assert property (
      LINK_ERR |=> s_q.err_code == $past(LINK_ERR_CODE))
      else $error("latest link error code not latched");

   a_temp_peak: assert property (
      !s_q.tick |=> s_q.temp_run >= $past(HEATSINK_TEMP))
      else $error("hourly temperature peak lost a sample");

   a_keypad_item: assert property (
      ITEM_SEL == ITM_KP_VER && !KEYPAD_ATTACHED |=> !ITEM_VALID && DISP == 16'h0000)
      else $error("keypad version shown without a keypad");

   a_menu_scope: assert property (
      ##1 MENU_SWITCH_OK == ($past(KEYPAD_MENU_SCOPE) == SCOPE_FULL))
      else $error("menu switch permission wrong for scope setting");

endmodule // ios_status_maint

/* File: src/ios_pkg.sv */
// How it works
// - forward run input sits in bit 0, backward run input in bit 1.
// - general inputs one to three sit in bits 2, 3 and 4.
// - every status bit without a terminal reads as 0.
// - an input bit is 1 while shorted to the input common, else 0.
// - output bit 0 is 1 while the transistor output is closed to its common.
// - output bit 8 is 1 for make contact closed, 0 for break contact closed.
// - input and output words are ORed into one four hex digit item, the link word is another; most significant on the left.
// - link view adds link forward and backward bits and has no output bits.
// - hours shown in four digits: one-hour steps below 10000, ten-hour steps above.
// - power-on hours wrap to zero after 65535 and keep counting.
// - board capacitor hours scale the same but stop and hold at 65535.
// - fan hours do not count while fan control has the fan stopped; they saturate.
// - each run command assertion counts one startup, shown with the same scaling.
// - link errors since power-on count up and return to zero past 9999.
// - the newest link error code replaces any earlier one.
// - highest heat-sink temperature within each hour is kept, in degrees.
// - highest effective output current within each hour is kept, in amperes.
// - bus capacitor capacitance is reported as percent of its shipment value.
// - the firmware version is readable as a four-digit maintenance item.
// - the keypad version item exists only while a remote keypad operates.
// - menu switching is allowed only when the menu scope setting equals 2.
package ios_pkg;
   // timebase: 25 MHz system clock, one hour of it per counter step
   localparam longint unsigned CLK_HZ   = 25_000_000;
   localparam longint unsigned HOUR_S   = 3600;
   localparam logic [39:0]     HOUR_CYC = 40'(HOUR_S * CLK_HZ);

   // status word bit positions
   localparam int BIT_FWD   = 0;
   localparam int BIT_BWD   = 1;
   localparam int BIT_GEN1  = 2;
   localparam int BIT_LFWD  = 13;
   localparam int BIT_LBWD  = 14;
   localparam int BIT_TOUT  = 0;
   localparam int BIT_RELAY = 8;

   // counter limits and scaling
   localparam logic [15:0] CNT_MAX    = 16'hffff;
   localparam logic [15:0] FINE_LIMIT = 16'h2710;   // 10000
   localparam logic [15:0] ERR_MAX    = 16'h270f;   // 9999
   localparam logic [15:0] SCALE_DIV  = 16'h000a;
   localparam logic [23:0] PCT_FULL   = 24'h000064; // 100 percent
   localparam logic [1:0]  SCOPE_FULL = 2'h2;

   // terminal and command levels seen by the block
   typedef struct packed {
      logic forward_run_input;
      logic backward_run_input;
      logic gen_input_one;
      logic gen_input_two;
      logic gen_input_three;
      logic transistor_output;
      logic relay_make_contact;
      logic link_forward_cmd;
      logic link_backward_cmd;
   } ios_terms_t;

   // four display digits, d4 leftmost
   typedef struct packed {
      logic [3:0] d4;
      logic [3:0] d3;
      logic [3:0] d2;
      logic [3:0] d1;
   } ios_digits_t;

   typedef enum logic [3:0] {
      ITM_IO_TERM   = 4'h0,
      ITM_IO_LINK   = 4'h1,
      ITM_RUN_HRS   = 4'h2,
      ITM_MAX_TEMP  = 4'h3,
      ITM_MAX_CUR   = 4'h4,
      ITM_CAP_PCT   = 4'h5,
      ITM_BOARD_HRS = 4'h6,
      ITM_FAN_HRS   = 4'h7,
      ITM_STARTS    = 4'h8,
      ITM_LINK_ERRS = 4'h9,
      ITM_LINK_CODE = 4'ha,
      ITM_FW_VER    = 4'hb,
      ITM_KP_VER    = 4'hc
   } ios_item_t;

   typedef struct packed {
      logic [39:0] pre;
      logic        tick;
      logic        run_prev;
      logic [15:0] hrs_run;
      logic [15:0] hrs_board;
      logic [15:0] hrs_fan;
      logic [15:0] starts;
      logic [15:0] err_cnt;
      logic [15:0] err_code;
      logic [7:0]  temp_run;
      logic [7:0]  temp_max;
      logic [15:0] cur_run;
      logic [15:0] cur_max;
      logic [15:0] in_word;
      logic [15:0] out_word;
      logic [15:0] link_word;
      ios_digits_t digits;
      logic        coarse;
      logic        valid;
      logic        menu_ok;
   } ios_state_t;

   localparam ios_state_t STATE_RST = '0;
endpackage

/* File: test/ios_term_model.sv */
`timescale 1ns/1ps
// terminal side of the drive: contact closures and link commands
module ios_term_model
   import ios_pkg::*;
(
   input  wire logic [4:0] in_short,
   input  wire logic       tr_closed,
   input  wire logic       make_closed,
   input  wire logic [1:0] link_cmd,
   output ios_terms_t      terms
);
   // break contact is closed whenever make is open, so one level carries both
   assign terms = '{in_short[0], in_short[1], in_short[2], in_short[3], in_short[4],
                    tr_closed, make_closed, link_cmd[0], link_cmd[1]};
endmodule // ios_term_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import ios_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [4:0]  in_short = 5'h0;
   logic        tr_closed = 1'b0;
   logic        make_closed = 1'b0;
   logic [1:0]  link_cmd = 2'h0;
   logic        fan_ctl = 1'b0;
   logic        fan_run = 1'b0;
   logic        run_cmd = 1'b0;
   logic        link_err = 1'b0;
   logic [15:0] link_code = 16'h0;
   logic [7:0]  heat = 8'h0;
   logic [15:0] cur = 16'h0;
   logic [15:0] cap_meas = 16'h0;
   logic [15:0] cap_ship = 16'h1;
   logic        kp_on = 1'b0;
   logic [15:0] kp_ver = 16'h4c2e;
   logic [1:0]  scope = 2'h0;
   ios_item_t   item_sel = ITM_IO_TERM;
   ios_terms_t  terms;
   logic [15:0] in_st, out_st, link_st, v0;
   ios_digits_t disp;
   logic        coarse, valid, menu_ok;
   int          seed = 23405;
   int          miscompares = 0;
   int          comparisons = 0;

   always #20 clk = ~clk;

   ios_term_model u_ios_term_model (.in_short(in_short), .tr_closed(tr_closed),
      .make_closed(make_closed), .link_cmd(link_cmd), .terms(terms));

   // short hour so the hour counters move within a short run
   ios_status_maint #(.HOUR_CYCLES(40'h14), .FW_VERSION(16'h0237)) u_ios_status_maint (
      .CLK(clk), .RST_N(rst_n), .TERMS(terms), .FAN_ONOFF_CONTROL(fan_ctl),
      .FAN_RUNNING(fan_run), .RUN_CMD(run_cmd), .LINK_ERR(link_err),
      .LINK_ERR_CODE(link_code), .HEATSINK_TEMP(heat), .OUT_CURRENT(cur),
      .CAP_MEAS(cap_meas), .CAP_SHIP(cap_ship), .KEYPAD_ATTACHED(kp_on),
      .KEYPAD_FW_VER(kp_ver), .KEYPAD_MENU_SCOPE(scope), .ITEM_SEL(item_sel),
      .IN_STATUS(in_st), .OUT_STATUS(out_st), .LINK_STATUS(link_st), .DISP(disp),
      .DISP_COARSE(coarse), .ITEM_VALID(valid), .MENU_SWITCH_OK(menu_ok));

   // expected words from terminal levels
   function automatic logic [15:0] in_exp(input logic [4:0] s);
      return {11'h0, s[4], s[3], s[2], s[1], s[0]};
   endfunction
   function automatic logic [15:0] out_exp(input logic tr, input logic mk);
      return {7'h0, mk, 7'h0, tr};
   endfunction
   function automatic logic [15:0] link_exp(input logic [4:0] s, input logic [1:0] l);
      return in_exp(s) | {1'b0, l[1], l[0], 13'h0};
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // readout takes a cycle to follow the selector; three edges leaves margin
   task automatic rd(input ios_item_t it, output logic [15:0] v);
      @(posedge clk);
      item_sel <= it;
      tick(3);
      v = disp;
   endtask

   task automatic status(input logic [4:0] s, input logic tr, input logic mk,
                         input logic [1:0] l);
      @(posedge clk);
      in_short <= s;
      tr_closed <= tr;
      make_closed <= mk;
      link_cmd <= l;
      item_sel <= ITM_IO_TERM;
      tick(3);
      chk("in_status", 32'(in_exp(s)), 32'(in_st));
      chk("out_status", 32'(out_exp(tr, mk)), 32'(out_st));
      chk("disp_term", 32'(in_exp(s) | out_exp(tr, mk)), 32'(disp));
      rd(ITM_IO_LINK, v0);
      chk("disp_link", {link_exp(s, l), link_exp(s, l)}, {v0, link_st});
   endtask

   // hour windows of exactly 100 edges hold exactly five hour ticks
   task automatic hours(input logic fc, input logic fr, input logic [15:0] fan_d);
      logic [15:0] b0, f0, r0;
      @(posedge clk);
      fan_ctl <= fc;
      fan_run <= fr;
      rd(ITM_BOARD_HRS, b0);
      rd(ITM_FAN_HRS, f0);
      rd(ITM_RUN_HRS, r0);
      tick(88);
      rd(ITM_BOARD_HRS, v0);
      chk("board_hrs", 32'(b0 + 16'h5), 32'(v0));
      rd(ITM_FAN_HRS, v0);
      chk("fan_hrs", 32'(f0 + fan_d), 32'(v0));
      rd(ITM_RUN_HRS, v0);
      chk("run_hrs", {r0 + 16'h5, 15'h0, 1'b0}, {v0, 15'h0, coarse});
   endtask

   // two full hours at one level, so the published maximum is that level
   task automatic maxima(input logic [7:0] t, input logic [15:0] a);
      @(posedge clk);
      heat <= t;
      cur <= a;
      tick(50);
      rd(ITM_MAX_TEMP, v0);
      chk("max_temp", 32'(t), 32'(v0));
      rd(ITM_MAX_CUR, v0);
      chk("max_cur", 32'(a), 32'(v0));
   endtask

   task automatic errs(input int n, input logic [15:0] cnt);
      logic [15:0] code;
      repeat (n) begin
         @(posedge clk);
         code = 16'($random(seed));
         link_err <= 1'b1;
         link_code <= code;
      end
      @(posedge clk);
      link_err <= 1'b0;
      rd(ITM_LINK_ERRS, v0);
      chk("err_cnt", 32'(cnt), 32'(v0));
      rd(ITM_LINK_CODE, v0);
      chk("err_code", 32'(code), 32'(v0));
   endtask

   task automatic starts(input int n, input logic [15:0] shown, input logic crs);
      repeat (n) begin
         @(posedge clk);
         run_cmd <= 1'b1;
         @(posedge clk);
         run_cmd <= 1'b0;
      end
      rd(ITM_STARTS, v0);
      chk("starts", {shown, 15'h0, crs}, {v0, 15'h0, coarse});
   endtask

   task automatic print_verdict();
      if (miscompares == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // main sequence: terminal corners, then random terminal levels, then the maintenance items
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      status(5'h05, 1'b0, 1'b0, 2'h0);
      status(5'h00, 1'b1, 1'b1, 2'h3);
      repeat (30) status(5'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                         2'($random(seed)));
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         scope <= 2'(s);
         tick(3);
         chk("menu_ok", 32'(s == 2), 32'(menu_ok));
      end
      rd(ITM_KP_VER, v0);
      chk("kp_off", 32'h0, {v0, 15'h0, valid});
      @(posedge clk);
      kp_on <= 1'b1;
      rd(ITM_KP_VER, v0);
      chk("kp_on", {kp_ver, 16'h1}, {v0, 15'h0, valid});
      rd(ITM_FW_VER, v0);
      chk("fw_ver", {16'h0237, 16'h1}, {v0, 15'h0, valid});
      rd(ios_item_t'(4'hd), v0);
      chk("bad_item", 32'h0, 32'(valid));
      repeat (5) begin
         @(posedge clk);
         cap_ship <= 16'(1 + {$random(seed)} % 250);
         cap_meas <= 16'({$random(seed)} % 300);
         rd(ITM_CAP_PCT, v0);
         chk("cap_pct", 32'(cap_meas * 100 / cap_ship), 32'(v0));
      end
      maxima(8'(100 + {$random(seed)} % 100), 16'(5000 + {$random(seed)} % 4999));
      maxima(8'({$random(seed)} % 100), 16'({$random(seed)} % 5000));
      hours(1'b0, 1'b0, 16'h5);
      hours(1'b1, 1'b1, 16'h5);
      hours(1'b1, 1'b0, 16'h0);
      errs(3, 16'h3);
      errs(9998, 16'h1);
      starts(7, 16'h7, 1'b0);
      starts(10003, 16'd1001, 1'b1);
      print_verdict();
   end

   // cut a hang short
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
endmodule // tb_top
